// >>> rtl/sfwp_pkg.sv
// Package for the serial flash write-protection block: field positions,
// reset values, command kinds and protection region geometry.
// Assumes a command decoder upstream that classifies each finished command.
// How it works
// - Protect bits select top or bottom blocks
// - Block program or erase into protected region
// - Chip erase only when protect bits zero
// - Status protected when disable bit and pin low
// - Hardware protection freezes non-volatile status bits
// - Writes ignored while write enable latch clear
// - Latch clears when write operation completes
// - Function register: locks, suspend flags, reserved zeros
// - Suspend flags read-only, writes never alter them
// - Suspend during program sets program flag
// - Resume of program clears program flag
// - Suspend during erase sets erase flag
// - Resume of erase clears erase flag
// - Lock bits set once, never cleared
// - Row program refused while its lock set
package sfwp_pkg;
    // Command kinds delivered by the command decoder
    typedef enum logic [3:0]
    {
        SFWP_CMD_NONE,
        SFWP_CMD_WRITE_ENABLE_CMD,
        SFWP_CMD_WRDI,
        SFWP_CMD_PROGRAM,
        SFWP_CMD_ERASE,
        SFWP_CMD_CHIP_ERASE,
        SFWP_CMD_WRITE_STATUS,
        SFWP_CMD_WRITE_FUNC,
        SFWP_CMD_INFO_PROGRAM,
        SFWP_CMD_SUSPEND,
        SFWP_CMD_RESUME
    } sfwp_cmd_t;

    // Operation state of the array engine
    typedef enum logic [2:0]
    {
        SFWP_IDLE,
        SFWP_PROG_RUN,
        SFWP_ERASE_RUN,
        SFWP_PROG_SUSP,
        SFWP_ERASE_SUSP,
        SFWP_REG_RUN
    } sfwp_op_t;

    // Geometry: 19-bit byte address, 64 KB blocks, 8 blocks
    localparam int SFWP_ADDR_W = 19;
    localparam int SFWP_BLOCK_SHIFT = 16;
    localparam int SFWP_BLOCKS = 8;
    localparam int SFWP_ROWS = 4;

    // Status byte field positions
    localparam int SFWP_ST_WIP = 0;
    localparam int SFWP_ST_WEL = 1;
    localparam int SFWP_ST_BP_LO = 2;
    localparam int SFWP_ST_QE = 6;
    localparam int SFWP_ST_STATUS_WRITE_DISABLE = 7;

    // Function register field positions
    localparam int SFWP_FR_PROGRAM_SUSPENDED_FLAG = 2;
    localparam int SFWP_FR_ERASE_SUSPENDED_FLAG = 3;
    localparam int SFWP_FR_IRL_LO = 4;

    // Reset values
    localparam logic [7:0] SFWP_FR_RESET = 8'h00;
    localparam logic [5:0] SFWP_NV_FACTORY = 6'h00;

    // Protect-code edges: codes 1..3 top, 12..14 bottom
    localparam logic [3:0] SFWP_BP_NONE_LO = 4'h0;
    localparam logic [3:0] SFWP_BP_NONE_HI = 4'hf;
    localparam logic [3:0] SFWP_BP_TOP_MAX = 4'h3;
    localparam logic [3:0] SFWP_BP_BOT_MIN = 4'hc;

    // Array operation time in link clock cycles (behavioural stand-in)
    localparam int SFWP_OP_CYCLES = 64;
endpackage : sfwp_pkg

// >>> rtl/sfwp_cmd_if.sv
// Interface carrying a classified command and its address from the
// command front end to the protection core; both sit on the link clock.
`timescale 1ns/1ps
interface sfwp_cmd_if;
    import sfwp_pkg::*;
    logic valid; // One-cycle command strobe
    sfwp_cmd_t kind; // Command kind
    logic [SFWP_ADDR_W-1:0] addr; // Target byte address or row index
    logic [7:0] data; // Register write data
    modport src (output valid, output kind, output addr, output data);
    modport dst (input valid, input kind, input addr, input data);
endinterface : sfwp_cmd_if

// >>> rtl/sfwp_sync.sv
// Two-flop level synchroniser for a pin or a signal from another clock.
// Assumes the input is a slowly changing level.
`timescale 1ns/1ps
module sfwp_sync
    import sfwp_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_reg; // First stage, read only by second stage
    logic [WIDTH-1:0] sync_reg; // Second stage

    // Both stages clear at reset
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= d_in;
            sync_reg <= meta_reg;
        end
    end

    assign q_out = sync_reg;
endmodule // sfwp_sync

// >>> rtl/sfwp_front.sv
// Command front end: registers the strobe, kind, address and data from
// the SPI decoder into the command interface. Assumes link-clock inputs.
`timescale 1ns/1ps
module sfwp_front
    import sfwp_pkg::*;
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic valid_in,
    input wire sfwp_cmd_t kind_in,
    input wire logic [SFWP_ADDR_W-1:0] addr_in,
    input wire logic [7:0] data_in,
    sfwp_cmd_if.src cmd
);
    // Capture one command per strobe
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cmd.valid <= 1'b0;
            cmd.kind <= SFWP_CMD_NONE;
            cmd.addr <= '0;
            cmd.data <= 8'h00;
        end
        else
        begin
            cmd.valid <= valid_in;
            cmd.kind <= kind_in;
            cmd.addr <= addr_in;
            cmd.data <= data_in;
        end
    end
endmodule // sfwp_front

// >>> rtl/sfwp_top.sv
// Write protection and function register of a small serial flash.
// Runs on the SPI clock; the write-protect pin and the external
// reset arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
module sfwp_top
    import sfwp_pkg::*;
#(
    parameter int OP_CYCLES = SFWP_OP_CYCLES
)
(
    input wire logic SYS_CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic SPI_CLK_IN,
    input wire logic WP_N_IN,
    input wire logic CMD_VALID_IN,
    input wire sfwp_cmd_t CMD_KIND_IN,
    input wire logic [SFWP_ADDR_W-1:0] CMD_ADDR_IN,
    input wire logic [7:0] CMD_DATA_IN,
    output logic [7:0] STATUS_OUT,
    output logic [7:0] FUNC_OUT,
    output logic ARRAY_WRITE_OUT,
    output logic REJECT_OUT,
    output logic [7:0] SYS_STATUS_OUT
);
    sfwp_cmd_if cmd ();
    logic wp_n_sync; // Synchronised write-protect pin, active low
    logic [7:0] stat_hold_reg; // Status word offered to the system side
    logic stat_req_reg; // Toggles with each offered word
    logic stat_req_sys; // Request on the system clock
    logic stat_ack_reg; // Toggles as the word is taken
    logic stat_ack_spi; // Acknowledge on the link clock
    logic [7:0] sys_status_reg; // Status copy on the system clock

    // Non-volatile cells: protect bits, quad enable, write disable, locks
    logic [3:0] prot_sel_reg = SFWP_NV_FACTORY[3:0]; // prot_sel_b3..prot_sel_b0, factory state
    logic quad_enable_reg = SFWP_NV_FACTORY[4]; // Quad enable
    logic status_write_disable_reg = SFWP_NV_FACTORY[5]; // Status write disable
    logic [SFWP_ROWS-1:0] info_row_lock_reg = '0; // info_row_lock_3..0
    // Volatile state
    logic write_enable_latch_reg; // Write enable latch
    logic program_suspended_flag_reg; // Program suspended
    logic erase_suspended_flag_reg; // Erase suspended
    sfwp_op_t op_reg; // Array engine state
    logic [15:0] op_cnt_reg; // Busy countdown
    logic array_write_reg; // One-cycle array commit
    logic reject_reg; // One-cycle refusal
    logic spi_rst_n; // Link reset released in link domain
    logic rst_meta_reg;
    logic rst_sync_reg;

    // Derived decisions
    logic [SFWP_BLOCKS-1:0] prot_mask; // Protected 64 KB blocks
    logic [2:0] tgt_block; // Block of the target address
    logic hw_protect; // Status register frozen
    logic busy; // Array or register write running
    logic accept; // Command allowed to run
    logic done; // Running write finished this cycle

    // Reset synchroniser for the link domain
    always_ff @(posedge SPI_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign spi_rst_n = rst_sync_reg;

    // Write-protect pin into the link domain
    sfwp_sync #(.WIDTH(1)) u_wp_sync
    (
        .clk_in(SPI_CLK_IN),
        .arst_n_in(spi_rst_n),
        .d_in(WP_N_IN),
        .q_out(wp_n_sync)
    );

    // Command capture
    sfwp_front u_front
    (
        .clk_in(SPI_CLK_IN),
        .arst_n_in(spi_rst_n),
        .valid_in(CMD_VALID_IN),
        .kind_in(CMD_KIND_IN),
        .addr_in(CMD_ADDR_IN),
        .data_in(CMD_DATA_IN),
        .cmd(cmd)
    );

    // Status into the system domain: word held, toggle request, acknowledge back
    always_ff @(posedge SPI_CLK_IN or negedge spi_rst_n)
    begin
        if (!spi_rst_n)
        begin
            stat_hold_reg <= 8'h00;
            stat_req_reg <= 1'b0;
        end
        else if (stat_req_reg == stat_ack_spi && STATUS_OUT != stat_hold_reg)
        begin
            stat_hold_reg <= STATUS_OUT;
            stat_req_reg <= !stat_req_reg;
        end
    end
    sfwp_sync u_req_sync (.clk_in(SYS_CLK_IN), .arst_n_in(ARST_N_IN), .d_in(stat_req_reg), .q_out(stat_req_sys));

    // Take the held word once per request toggle
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            sys_status_reg <= 8'h00;
            stat_ack_reg <= 1'b0;
        end
        else if (stat_req_sys != stat_ack_reg)
        begin
            sys_status_reg <= stat_hold_reg;
            stat_ack_reg <= stat_req_sys;
        end
    end
    sfwp_sync u_ack_sync (.clk_in(SPI_CLK_IN), .arst_n_in(spi_rst_n), .d_in(stat_ack_reg), .q_out(stat_ack_spi));
    assign SYS_STATUS_OUT = sys_status_reg;

    // Protected block map from the protect code
    always_comb
    begin
        prot_mask = '0;
        if (prot_sel_reg == SFWP_BP_NONE_LO || prot_sel_reg == SFWP_BP_NONE_HI)
        begin
            prot_mask = '0;
        end
        else if (prot_sel_reg <= SFWP_BP_TOP_MAX)
        begin
            // Top 1, 2 or 4 blocks
            for (int i = 0; i < SFWP_BLOCKS; i++)
            begin
                prot_mask[i] = (i >= SFWP_BLOCKS - (1 << (prot_sel_reg - 1)));
            end
        end
        else if (prot_sel_reg >= SFWP_BP_BOT_MIN)
        begin
            // Bottom 4, 2 or 1 blocks
            for (int i = 0; i < SFWP_BLOCKS; i++)
            begin
                prot_mask[i] = (i < (1 << (SFWP_BP_NONE_HI - 1 - prot_sel_reg)));
            end
        end
        else
        begin
            prot_mask = '1;
        end
    end

    assign tgt_block = cmd.addr[SFWP_ADDR_W-1:SFWP_BLOCK_SHIFT];
    assign hw_protect = status_write_disable_reg && !wp_n_sync;
    assign busy = (op_reg == SFWP_PROG_RUN) || (op_reg == SFWP_ERASE_RUN) || (op_reg == SFWP_REG_RUN);
    assign done = busy && (op_cnt_reg == 16'h0000);

    // Admission check for write-type commands
    always_comb
    begin
        accept = 1'b0;
        if (cmd.valid && write_enable_latch_reg && op_reg == SFWP_IDLE)
        begin
            case (cmd.kind)
                SFWP_CMD_PROGRAM: accept = !prot_mask[tgt_block];
                SFWP_CMD_ERASE: accept = !prot_mask[tgt_block];
                SFWP_CMD_CHIP_ERASE: accept = (prot_sel_reg == 4'h0);
                SFWP_CMD_WRITE_STATUS: accept = !hw_protect;
                SFWP_CMD_WRITE_FUNC: accept = 1'b1;
                SFWP_CMD_INFO_PROGRAM: accept = !info_row_lock_reg[cmd.addr[1:0]];
                default: accept = 1'b0;
            endcase
        end
    end

    // Non-volatile cells: kept through reset, loaded only by writes
    always_ff @(posedge SPI_CLK_IN)
    begin
        if (accept && cmd.kind == SFWP_CMD_WRITE_STATUS)
        begin
            prot_sel_reg <= cmd.data[SFWP_ST_BP_LO +: 4];
            quad_enable_reg <= cmd.data[SFWP_ST_QE];
            status_write_disable_reg <= cmd.data[SFWP_ST_STATUS_WRITE_DISABLE];
        end
        if (accept && cmd.kind == SFWP_CMD_WRITE_FUNC)
        begin
            info_row_lock_reg <= info_row_lock_reg | cmd.data[SFWP_FR_IRL_LO +: SFWP_ROWS];
        end
    end

    // Write enable latch
    always_ff @(posedge SPI_CLK_IN or negedge spi_rst_n)
    begin
        if (!spi_rst_n)
        begin
            write_enable_latch_reg <= 1'b0;
        end
        else if (done)
        begin
            write_enable_latch_reg <= 1'b0;
        end
        else if (cmd.valid && !busy && cmd.kind == SFWP_CMD_WRITE_ENABLE_CMD)
        begin
            write_enable_latch_reg <= 1'b1;
        end
        else if (cmd.valid && !busy && cmd.kind == SFWP_CMD_WRDI)
        begin
            write_enable_latch_reg <= 1'b0;
        end
    end

    // Array engine with suspend and resume
    always_ff @(posedge SPI_CLK_IN or negedge spi_rst_n)
    begin
        if (!spi_rst_n)
        begin
            op_reg <= SFWP_IDLE;
            op_cnt_reg <= 16'h0000;
        end
        else if (accept)
        begin
            op_cnt_reg <= 16'(OP_CYCLES - 1);
            case (cmd.kind)
                SFWP_CMD_PROGRAM, SFWP_CMD_INFO_PROGRAM: op_reg <= SFWP_PROG_RUN;
                SFWP_CMD_ERASE, SFWP_CMD_CHIP_ERASE: op_reg <= SFWP_ERASE_RUN;
                default: op_reg <= SFWP_REG_RUN;
            endcase
        end
        else if (cmd.valid && cmd.kind == SFWP_CMD_SUSPEND && op_reg == SFWP_PROG_RUN)
        begin
            op_reg <= SFWP_PROG_SUSP;
        end
        else if (cmd.valid && cmd.kind == SFWP_CMD_SUSPEND && op_reg == SFWP_ERASE_RUN)
        begin
            op_reg <= SFWP_ERASE_SUSP;
        end
        else if (cmd.valid && cmd.kind == SFWP_CMD_RESUME && op_reg == SFWP_PROG_SUSP)
        begin
            op_reg <= SFWP_PROG_RUN;
        end
        else if (cmd.valid && cmd.kind == SFWP_CMD_RESUME && op_reg == SFWP_ERASE_SUSP)
        begin
            op_reg <= SFWP_ERASE_RUN;
        end
        else if (done)
        begin
            op_reg <= SFWP_IDLE;
        end
        else if (busy)
        begin
            op_cnt_reg <= op_cnt_reg - 16'h0001;
        end
    end

    // Suspend flags follow the engine, never the register write
    always_ff @(posedge SPI_CLK_IN or negedge spi_rst_n)
    begin
        if (!spi_rst_n)
        begin
            program_suspended_flag_reg <= 1'b0;
            erase_suspended_flag_reg <= 1'b0;
        end
        else if (cmd.valid)
        begin
            if (cmd.kind == SFWP_CMD_SUSPEND && op_reg == SFWP_PROG_RUN)
            begin
                program_suspended_flag_reg <= 1'b1;
            end
            else if (cmd.kind == SFWP_CMD_RESUME && op_reg == SFWP_PROG_SUSP)
            begin
                program_suspended_flag_reg <= 1'b0;
            end
            if (cmd.kind == SFWP_CMD_SUSPEND && op_reg == SFWP_ERASE_RUN)
            begin
                erase_suspended_flag_reg <= 1'b1;
            end
            else if (cmd.kind == SFWP_CMD_RESUME && op_reg == SFWP_ERASE_SUSP)
            begin
                erase_suspended_flag_reg <= 1'b0;
            end
        end
    end

    // Commit and refusal pulses
    always_ff @(posedge SPI_CLK_IN or negedge spi_rst_n)
    begin
        if (!spi_rst_n)
        begin
            array_write_reg <= 1'b0;
            reject_reg <= 1'b0;
        end
        else
        begin
            array_write_reg <= done && (op_reg != SFWP_REG_RUN);
            reject_reg <= cmd.valid && !accept && (cmd.kind inside {SFWP_CMD_PROGRAM, SFWP_CMD_ERASE,
                SFWP_CMD_CHIP_ERASE, SFWP_CMD_WRITE_STATUS, SFWP_CMD_WRITE_FUNC, SFWP_CMD_INFO_PROGRAM});
        end
    end

    // Register readback; reserved bits read zero
    always_comb
    begin
        STATUS_OUT = 8'h00;
        STATUS_OUT[SFWP_ST_WIP] = busy;
        STATUS_OUT[SFWP_ST_WEL] = write_enable_latch_reg;
        STATUS_OUT[SFWP_ST_BP_LO +: 4] = prot_sel_reg;
        STATUS_OUT[SFWP_ST_QE] = quad_enable_reg;
        STATUS_OUT[SFWP_ST_STATUS_WRITE_DISABLE] = status_write_disable_reg;
        FUNC_OUT = SFWP_FR_RESET;
        FUNC_OUT[SFWP_FR_PROGRAM_SUSPENDED_FLAG] = program_suspended_flag_reg;
        FUNC_OUT[SFWP_FR_ERASE_SUSPENDED_FLAG] = erase_suspended_flag_reg;
        FUNC_OUT[SFWP_FR_IRL_LO +: SFWP_ROWS] = info_row_lock_reg;
    end

    assign ARRAY_WRITE_OUT = array_write_reg;
    assign REJECT_OUT = reject_reg;
endmodule // sfwp_top

// >>> verif/sfwp_top_assertions.sv
// Checker on the top-level ports of the write-protection block.
// Assumes commands arrive at least three link cycles apart.
`timescale 1ns/1ps
module sfwp_top_assertions
    import sfwp_pkg::*;
#(
    parameter int OP_CYCLES = SFWP_OP_CYCLES
)
(
    input wire logic SYS_CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic SPI_CLK_IN,
    input wire logic WP_N_IN,
    input wire logic CMD_VALID_IN,
    input wire sfwp_cmd_t CMD_KIND_IN,
    input wire logic [SFWP_ADDR_W-1:0] CMD_ADDR_IN,
    input wire logic [7:0] CMD_DATA_IN,
    input wire logic [7:0] STATUS_OUT,
    input wire logic [7:0] FUNC_OUT,
    input wire logic ARRAY_WRITE_OUT,
    input wire logic REJECT_OUT,
    input wire logic [7:0] SYS_STATUS_OUT
);
    logic [3:0] susp_age_reg; // Link cycles since the last suspend strobe
    // Saturating age, so an old suspend never looks recent
    always_ff @(posedge SPI_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
            susp_age_reg <= 4'hf;
        else if (CMD_VALID_IN && CMD_KIND_IN == SFWP_CMD_SUSPEND)
            susp_age_reg <= 4'h0;
        else if (susp_age_reg != 4'hf)
            susp_age_reg <= susp_age_reg + 4'h1;
    end
    default clocking @(posedge SPI_CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);
    // Request while idle with the latch set
    sequence armed;
        CMD_VALID_IN && STATUS_OUT[1:0] == 2'b10;
    endsequence
    // Refusal pulse after the request
    sequence refused;
        ##2 REJECT_OUT;
    endsequence
    unlatched_refused_a: assert property (CMD_VALID_IN && CMD_KIND_IN == SFWP_CMD_PROGRAM &&
        STATUS_OUT[1:0] == 2'b00 |-> refused) else $error("program without latch not refused");
    region_refused_a: assert property (armed ##0 (CMD_KIND_IN inside {SFWP_CMD_PROGRAM, SFWP_CMD_ERASE})
        ##0 ((STATUS_OUT[5:2] inside {4'h1, 4'h2, 4'h3} && CMD_ADDR_IN[18:16] == 3'h7) ||
        (STATUS_OUT[5:2] inside {4'hc, 4'hd, 4'he} && CMD_ADDR_IN[18:16] == 3'h0)) |-> refused)
        else $error("protected block write not refused");
    chip_refused_a: assert property (armed ##0 (CMD_KIND_IN == SFWP_CMD_CHIP_ERASE &&
        STATUS_OUT[5:2] != 4'h0) |-> refused) else $error("chip erase with protection not refused");
    status_locked_a: assert property (armed ##0 (CMD_KIND_IN == SFWP_CMD_WRITE_STATUS &&
        STATUS_OUT[7] && !WP_N_IN) |-> refused) else $error("locked status write not refused");
    status_frozen_a: assert property (armed ##0 (CMD_KIND_IN == SFWP_CMD_WRITE_STATUS &&
        STATUS_OUT[7] && !WP_N_IN) |=> $stable(STATUS_OUT[7:2])[*6]) else $error("locked status changed");
    row_refused_a: assert property (armed ##0 (CMD_KIND_IN == SFWP_CMD_INFO_PROGRAM &&
        FUNC_OUT[3'd4 + CMD_ADDR_IN[1:0]]) |-> refused) else $error("locked row program not refused");
    latch_cleared_a: assert property (ARRAY_WRITE_OUT |-> STATUS_OUT[1:0] == 2'b00)
        else $error("latch or busy set at completion");
    flags_readonly_a: assert property (CMD_VALID_IN && CMD_KIND_IN == SFWP_CMD_WRITE_FUNC
        |=> $stable(FUNC_OUT[3:2])[*6]) else $error("suspend flags written");
    lock_sticky_a: assert property ((FUNC_OUT[7:4] & $past(FUNC_OUT[7:4])) == $past(FUNC_OUT[7:4]))
        else $error("row lock cleared");
    suspend_recent_a: assert property ($rose(FUNC_OUT[2]) || $rose(FUNC_OUT[3])
        |-> susp_age_reg <= 4'h3) else $error("suspend flag set without suspend");
endmodule // sfwp_top_assertions
bind sfwp_top sfwp_top_assertions #(.OP_CYCLES(OP_CYCLES)) sfwp_top_assertions_i (.SYS_CLK_IN(SYS_CLK_IN),
    .ARST_N_IN(ARST_N_IN), .SPI_CLK_IN(SPI_CLK_IN), .WP_N_IN(WP_N_IN), .CMD_VALID_IN(CMD_VALID_IN),
    .CMD_KIND_IN(CMD_KIND_IN), .CMD_ADDR_IN(CMD_ADDR_IN), .CMD_DATA_IN(CMD_DATA_IN), .STATUS_OUT(STATUS_OUT),
    .FUNC_OUT(FUNC_OUT), .ARRAY_WRITE_OUT(ARRAY_WRITE_OUT), .REJECT_OUT(REJECT_OUT),
    .SYS_STATUS_OUT(SYS_STATUS_OUT));

// >>> verif/sfwp_host_model.sv
// Host-side command source for the decoded command pins.
// Launches on falling link edges so the block samples settled values.
`timescale 1ns/1ps
module sfwp_host_model
    import sfwp_pkg::*;
(
    input wire logic clk_in,
    output logic valid_out,
    output sfwp_cmd_t kind_out,
    output logic [SFWP_ADDR_W-1:0] addr_out,
    output logic [7:0] data_out
);
    int gap = 1; // Idle cycles after each strobe, set by the bench
    // Quiet lines at time zero
    initial
    begin
        valid_out = 1'b0;
        kind_out = SFWP_CMD_NONE;
        addr_out = '0;
        data_out = 8'h00;
    end
    // One-cycle strobe; released address and data lines show the inverse value
    task automatic send(input sfwp_cmd_t k, input logic [SFWP_ADDR_W-1:0] a, input logic [7:0] d);
        @(negedge clk_in);
        valid_out = 1'b1;
        kind_out = k;
        addr_out = a;
        data_out = d;
        @(negedge clk_in);
        valid_out = 1'b0;
        kind_out = SFWP_CMD_NONE;
        addr_out = ~a;
        data_out = ~d;
        repeat (gap) @(negedge clk_in);
    endtask
    // Write enable ahead of a write command
    task automatic send_write(input sfwp_cmd_t k, input logic [SFWP_ADDR_W-1:0] a, input logic [7:0] d);
        send(SFWP_CMD_WRITE_ENABLE_CMD, '0, 8'h00);
        send(k, a, d);
    endtask
endmodule // sfwp_host_model

// >>> verif/serial_flash_write_protection_bench.sv
// Self-checking bench for the flash write-protection block.
// Host model sends commands; integer model predicts every result.
`timescale 1ns/1ps
module serial_flash_write_protection_bench;
    import sfwp_pkg::*;
    localparam int OPC = 8; // Short array operation time
    logic sys_clk = 1'b0; // System clock
    logic spi_clk = 1'b0; // Link clock
    logic arst_n = 1'b0; // Reset, active low
    logic wp_n = 1'b1; // Write-protect pin
    logic valid; // Command strobe
    sfwp_cmd_t kind; // Command kind
    logic [SFWP_ADDR_W-1:0] addr; // Command address
    logic [7:0] data, st, fr, sst; // Command data and register views
    logic awr, rej; // Completion and refusal pulses
    int err_count = 0, samples_checked = 0, n_wr = 0, n_rej = 0;
    int bp = 0, qe = 0, status_write_disable = 0, locks = 0; // Model of non-volatile bits
    logic [31:0] seed = 32'hb895f777; // Random state
    always #12.5 sys_clk = ~sys_clk;
    always #16 spi_clk = ~spi_clk;
    // Count result pulses
    always @(negedge spi_clk)
    begin
        n_wr += (awr === 1'b1);
        n_rej += (rej === 1'b1);
    end
    sfwp_top #(.OP_CYCLES(OPC)) sfwp_top_i (.SYS_CLK_IN(sys_clk), .ARST_N_IN(arst_n), .SPI_CLK_IN(spi_clk),
        .WP_N_IN(wp_n), .CMD_VALID_IN(valid), .CMD_KIND_IN(kind), .CMD_ADDR_IN(addr), .CMD_DATA_IN(data),
        .STATUS_OUT(st), .FUNC_OUT(fr), .ARRAY_WRITE_OUT(awr), .REJECT_OUT(rej), .SYS_STATUS_OUT(sst));
    sfwp_host_model sfwp_host_model_i (.clk_in(spi_clk), .valid_out(valid), .kind_out(kind),
        .addr_out(addr), .data_out(data));
    // Next random word
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    // Block covered by a protect code
    function automatic bit blk_prot(input int c, input int b);
        if (c >= 1 && c <= 3)
            return b >= 8 - (1 << (c - 1));
        if (c >= 12 && c <= 14)
            return b < (1 << (14 - c));
        return c != 0 && c != 15;
    endfunction
    // Counts, verdict, end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Compare one value with its expectation
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Compare register views, the synced copy included
    task automatic chk_regs();
        logic [7:0] exp;
        exp = {status_write_disable[0], qe[0], 4'(bp), 2'b00};
        repeat (8) @(posedge sys_clk);
        #5;
        cmp(st, exp, "status");
        cmp(sst, exp, "synced status");
        cmp(fr, {4'(locks), 4'h0}, "function");
    endtask
    // One write command with refusal, completion and register checks
    task automatic op(input sfwp_cmd_t k, input int a, input logic [7:0] d, input bit write_enable_cmd);
        int r0, w0, i;
        bit no;
        no = !write_enable_cmd;
        case (k)
            SFWP_CMD_PROGRAM, SFWP_CMD_ERASE: no |= blk_prot(bp, a >> 16);
            SFWP_CMD_CHIP_ERASE: no |= (bp != 0);
            SFWP_CMD_WRITE_STATUS: no |= (status_write_disable != 0 && !wp_n);
            SFWP_CMD_INFO_PROGRAM: no |= locks[a % 4];
            default: ;
        endcase
        r0 = n_rej;
        w0 = n_wr;
        sfwp_host_model_i.gap = 1 + int'(rnd() % 3);
        if (write_enable_cmd)
            sfwp_host_model_i.send_write(k, SFWP_ADDR_W'(a), d);
        else
            sfwp_host_model_i.send(k, SFWP_ADDR_W'(a), d);
        i = 0;
        do
        begin
            @(negedge spi_clk);
            i++;
        end
        while ((st[0] !== 1'b0 || i < 4) && i < 200);
        repeat (3) @(negedge spi_clk);
        if (i >= 200)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: busy never dropped", $time);
            finish_test();
        end
        cmp(8'(n_rej - r0), {7'h0, no}, "refusal");
        if (k inside {SFWP_CMD_PROGRAM, SFWP_CMD_ERASE, SFWP_CMD_CHIP_ERASE})
            cmp(8'(n_wr - w0), {7'h0, !no}, "array write");
        if (!no && k == SFWP_CMD_WRITE_STATUS)
            {status_write_disable, qe, bp} = {31'h0, d[7], 31'h0, d[6], 28'h0, d[5:2]};
        if (!no && k == SFWP_CMD_WRITE_FUNC)
            locks |= d[7:4];
        if (no && write_enable_cmd)
            sfwp_host_model_i.send(SFWP_CMD_WRDI, '0, 8'h00);
        chk_regs();
    endtask
    // Suspend and resume a running operation
    task automatic susp(input sfwp_cmd_t k, input logic [1:0] flag);
        int w0;
        w0 = n_wr;
        sfwp_host_model_i.gap = 1;
        sfwp_host_model_i.send_write(k, SFWP_ADDR_W'(rnd()), 8'h00);
        sfwp_host_model_i.send(SFWP_CMD_SUSPEND, '0, 8'h00);
        repeat (2) @(negedge spi_clk);
        cmp(fr, {4'(locks), flag, 2'b00}, "suspend flag");
        sfwp_host_model_i.send(SFWP_CMD_RESUME, '0, 8'h00);
        repeat (2) @(negedge spi_clk);
        cmp(fr, {4'(locks), 4'h0}, "resume flag");
        repeat (OPC + 4) @(negedge spi_clk);
        cmp(8'(n_wr - w0), 8'h01, "resumed write");
        chk_regs();
    endtask
    // Main sequence
    initial
    begin
        repeat (6) @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge spi_clk);
        chk_regs();
        op(SFWP_CMD_PROGRAM, 0, 8'h00, 0);
        op(SFWP_CMD_WRITE_STATUS, 0, 8'h3c, 0);
        $display("latch gating done");
        for (int c = 0; c < 16; c++)
        begin
            op(SFWP_CMD_WRITE_STATUS, 0, 8'(c << 2), 1);
            for (int b = 0; b < 8; b++)
                op(b % 2 ? SFWP_CMD_ERASE : SFWP_CMD_PROGRAM, (b << 16) + int'(rnd() % 65536), 8'h00, 1);
            op(SFWP_CMD_CHIP_ERASE, 0, 8'h00, 1);
        end
        $display("protect decode done");
        for (int i = 0; i < 4; i++)
        begin
            op(SFWP_CMD_WRITE_STATUS, 0, {i[1], 7'h00}, 1);
            @(negedge sys_clk);
            wp_n = i[0];
            op(SFWP_CMD_WRITE_STATUS, 0, 8'h44, 1);
            @(negedge sys_clk);
            wp_n = 1'b1;
        end
        op(SFWP_CMD_WRITE_STATUS, 0, 8'h00, 1);
        $display("hardware protection done");
        op(SFWP_CMD_WRITE_FUNC, 0, (8'(rnd()) & 8'h3f) | 8'h1c, 1);
        op(SFWP_CMD_WRITE_FUNC, 0, 8'h00, 1);
        for (int r = 0; r < 4; r++)
            op(SFWP_CMD_INFO_PROGRAM, r, 8'h00, 1);
        $display("row locks done");
        susp(SFWP_CMD_PROGRAM, 2'b01);
        susp(SFWP_CMD_ERASE, 2'b10);
        $display("suspend done");
        op(SFWP_CMD_WRITE_STATUS, 0, 8'h48, 1);
        sfwp_host_model_i.send(SFWP_CMD_WRITE_ENABLE_CMD, '0, 8'h00);
        @(negedge sys_clk);
        arst_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge spi_clk);
        chk_regs();
        $display("second reset done");
        finish_test();
    end
endmodule // serial_flash_write_protection_bench
